/* File: csrw_pkg.sv */
// Package with constants and carrier types for the cpu supervisor
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`default_nettype none
package csrw_pkg;
  // Clock and times
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned HOLD_MS = 200;
  localparam int unsigned WDOG_MS = 1600;
  localparam int unsigned WDOG_INT_MS = 1400;
  localparam int unsigned CS_EXT_US = 15;
  localparam int unsigned DEB_MS = 1;
  // Derived cycle counts (longest or least as appropriate)
  localparam int unsigned HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
  localparam int unsigned WDOG_CYC = CLK_HZ / 1000 * WDOG_MS;
  localparam int unsigned WDOG_INT_CYC = CLK_HZ / 1000 * WDOG_INT_MS;
  localparam int unsigned CS_EXT_CYC = CLK_HZ / 1_000_000 * CS_EXT_US;
  localparam int unsigned DEB_CYC = CLK_HZ / 1000 * DEB_MS;
  localparam int unsigned CNT_W = 32;

  // Analog comparator results
  typedef struct packed {
    logic below_reset;    // supply below reset_threshold
    logic below_backup;   // supply below backup_voltage
    logic sense_low;      // supply_sense_in below fail_threshold
  } csrw_cmp_t;

  // RAM rail selection
  typedef enum logic [1:0] {
    CSRW_RAIL_MAIN = 2'b00,
    CSRW_RAIL_BACKUP = 2'b01,
    CSRW_RAIL_OFF = 2'b11
  } csrw_rail_t;

  // Reset sequencer states, Gray along the usual path
  typedef enum logic [1:0] {
    CSRW_ST_LOW = 2'b00,
    CSRW_ST_HOLD = 2'b01,
    CSRW_ST_RUN = 2'b11
  } csrw_state_t;
endpackage : csrw_pkg
`default_nettype wire

/* File: csrw_debounce.sv */
// Manual reset debouncer: output follows input after a stable interval
`default_nettype none
module csrw_debounce
  import csrw_pkg::*;
#(
  parameter int unsigned STABLE_CYC = DEB_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Raw and filtered level
  input wire logic raw_in,
  output logic clean_out
);
  logic [CNT_W-1:0] cnt_r;
  logic clean_r;
  wire differs = raw_in != clean_r;
  wire settled = cnt_r >= STABLE_CYC - 1;

  // Count while the input disagrees, accept once stable
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt_r <= '0;
      clean_r <= 1'b1;
    end
    else if (!differs)
      cnt_r <= '0;
    else if (settled)
    begin
      cnt_r <= '0;
      clean_r <= raw_in;
    end
    else
      cnt_r <= cnt_r + 1'b1;
  end

  assign clean_out = clean_r;
endmodule : csrw_debounce
`default_nettype wire

/* File: csrw_watchdog.sv */
// Watchdog timer with internal keep-alive driver for undriven input
`default_nettype none
module csrw_watchdog
  import csrw_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = WDOG_CYC,
  parameter int unsigned KEEP_CYC = WDOG_INT_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic hold_clear,
  input wire logic wdi_driven,
  input wire logic wdi_level,
  // Result
  output logic expire
);
  logic [CNT_W-1:0] cnt_r;
  logic last_r;
  logic expire_r;
  // Internal driver pulses high at seven-eighths of the period
  wire int_level = cnt_r >= KEEP_CYC - 1;
  wire level = wdi_driven ? wdi_level : int_level;
  wire edge_seen = level != last_r;
  wire timed_out = cnt_r >= PERIOD_CYC - 1;

  // Counter clears on reset or on any edge
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt_r <= '0;
      last_r <= 1'b0;
      expire_r <= 1'b0;
    end
    else
    begin
      last_r <= level;
      expire_r <= 1'b0;
      if (hold_clear)
        cnt_r <= '0;
      else if (edge_seen)
        cnt_r <= '0;
      else if (timed_out)
      begin
        cnt_r <= '0;
        expire_r <= 1'b1;
      end
      else
        cnt_r <= cnt_r + 1'b1;
    end
  end

  assign expire = expire_r;
endmodule : csrw_watchdog
`default_nettype wire

/* File: csrw_supervisor.sv */
// Top of the cpu supervisor: reset, chip-select gate, fail flag, backup
`default_nettype none
module csrw_supervisor
  import csrw_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_CYC,
  parameter int unsigned WDOG_CYCLES = WDOG_CYC,
  parameter int unsigned WDOG_KEEP_CYCLES = WDOG_INT_CYC,
  parameter int unsigned DEB_CYCLES = DEB_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Comparator results
  input wire csrw_pkg::csrw_cmp_t cmp,
  // Manual reset and watchdog
  input wire logic manual_reset_n,
  input wire logic watchdog_toggle_in,
  input wire logic watchdog_driven,
  // Seal strap sense: fail or chip-select pin held low externally
  input wire logic seal_strap_low,
  // Chip-select gate
  input wire logic chip_sel_in_n,
  output logic chip_sel_out_n,
  output logic chip_sel_pullup,
  output logic chip_sel_in_hiz,
  // Outputs to processor and system
  output logic reset_n,
  output logic supply_fail_n,
  output csrw_pkg::csrw_rail_t ram_rail,
  output logic backup_connected
);
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  csrw_state_t state_r;
  csrw_state_t state_nxt;
  logic [CNT_W-1:0] hold_cnt_r;
  logic [CNT_W-1:0] cs_cnt_r;
  logic cs_ext_r;
  logic seal_r;
  logic seal_arm_r;
  logic reset_n_r;
  logic fail_n_r;
  logic cs_out_r;
  logic pullup_r;
  logic hiz_r;
  csrw_rail_t rail_r;
  logic backup_supply_in_r;
  logic mr_clean;
  logic wd_expire;
  logic wd_clear;

  // ----------------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------------
  csrw_debounce #(
    .STABLE_CYC(DEB_CYCLES)
  ) u_deb (
    .clk(clk),
    .rst_b(rst_b),
    .raw_in(manual_reset_n),
    .clean_out(mr_clean)
  );

  csrw_watchdog #(
    .PERIOD_CYC(WDOG_CYCLES),
    .KEEP_CYC(WDOG_KEEP_CYCLES)
  ) u_wd (
    .clk(clk),
    .rst_b(rst_b),
    .hold_clear(wd_clear),
    .wdi_driven(watchdog_driven),
    .wdi_level(watchdog_toggle_in),
    .expire(wd_expire)
  );

  // ----------------------------------------------------------------------
  // Decode of conditions
  // ----------------------------------------------------------------------
  // Backup needs supply below both threshold and battery
  wire backup_mode = cmp.below_reset & cmp.below_backup;
  // Manual reset ignored during hold when seal enabled
  wire seal_hold = seal_r && state_r == CSRW_ST_HOLD;
  wire mr_active = !mr_clean && !seal_hold;
  wire force_low = cmp.below_reset | mr_active;
  wire in_reset = state_r != CSRW_ST_RUN;
  wire in_hold = state_r == CSRW_ST_HOLD;
  wire hold_done = hold_cnt_r >= HOLD_CYCLES - 1;
  // Watchdog cleared in reset and in backup mode
  assign wd_clear = in_reset | backup_mode | force_low;
  wire reset_start = state_r == CSRW_ST_RUN && (force_low || wd_expire);
  wire cs_ext_done = cs_cnt_r >= CS_EXT_CYC - 1;

  // ----------------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------------
  // Next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      CSRW_ST_LOW:
        if (!force_low)
          state_nxt = CSRW_ST_HOLD;
      CSRW_ST_HOLD:
        if (force_low)
          state_nxt = CSRW_ST_LOW;
        else if (hold_done)
          state_nxt = CSRW_ST_RUN;
      CSRW_ST_RUN:
        if (force_low)
          state_nxt = CSRW_ST_LOW;
        else if (wd_expire)
          state_nxt = CSRW_ST_HOLD;
      default:
        state_nxt = CSRW_ST_LOW;
    endcase
  end

  // State and hold counter, counter restarts on every reset entry
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_r <= CSRW_ST_LOW;
      hold_cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_nxt == CSRW_ST_HOLD && state_r == CSRW_ST_HOLD)
        hold_cnt_r <= hold_cnt_r + 1'b1;
      else
        hold_cnt_r <= '0;
    end
  end

  // Reset output, held low in backup mode
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      reset_n_r <= 1'b0;
    else
      reset_n_r <= (state_nxt == CSRW_ST_RUN) && !backup_mode;
  end

  // ----------------------------------------------------------------------
  // Freshness seal
  // ----------------------------------------------------------------------
  // Arm while strap low and manual reset high through a hold completion;
  // seal on the next supply drop, clear on next rise above threshold
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      seal_arm_r <= 1'b0;
      seal_r <= 1'b0;
    end
    else
    begin
      if (!seal_strap_low || !mr_clean)
        seal_arm_r <= 1'b0;
      else if (in_hold && hold_done)
        seal_arm_r <= 1'b1;
      if (seal_arm_r && cmp.below_reset)
      begin
        seal_r <= 1'b1;
        seal_arm_r <= 1'b0;
      end
      else if (seal_r && !cmp.below_reset && state_r == CSRW_ST_LOW)
        seal_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // RAM rail selection
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rail_r <= CSRW_RAIL_MAIN;
      backup_supply_in_r <= 1'b0;
    end
    else if (!backup_mode)
    begin
      rail_r <= CSRW_RAIL_MAIN;
      backup_supply_in_r <= 1'b0;
    end
    else
    begin
      // Sealed battery stays disconnected
      rail_r <= seal_r ? CSRW_RAIL_OFF : CSRW_RAIL_BACKUP;
      backup_supply_in_r <= !seal_r;
    end
  end

  // ----------------------------------------------------------------------
  // Supply fail flag
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      fail_n_r <= 1'b1;
    else if (cmp.below_backup)
      fail_n_r <= 1'b0;
    else if (in_hold)
      fail_n_r <= 1'b1;
    else
      fail_n_r <= !cmp.sense_low;
  end

  // ----------------------------------------------------------------------
  // Chip-select gate
  // ----------------------------------------------------------------------
  // Extension window when chip-select is low at reset entry
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cs_ext_r <= 1'b0;
      cs_cnt_r <= '0;
    end
    else if (reset_start)
    begin
      cs_ext_r <= !chip_sel_in_n;
      cs_cnt_r <= '0;
    end
    else if (cs_ext_r)
    begin
      cs_cnt_r <= cs_cnt_r + 1'b1;
      if (cs_ext_done || chip_sel_in_n)
        cs_ext_r <= 1'b0;
    end
  end

  // Gate enabled when not in reset, or during a pending write extension
  wire gate_on = (state_nxt == CSRW_ST_RUN && !backup_mode) ||
                 (cs_ext_r && !chip_sel_in_n && !cs_ext_done) ||
                 (reset_start && !chip_sel_in_n);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cs_out_r <= 1'b1;
      pullup_r <= 1'b1;
      hiz_r <= 1'b1;
    end
    else
    begin
      cs_out_r <= gate_on ? chip_sel_in_n : 1'b1;
      pullup_r <= !gate_on;
      hiz_r <= !gate_on;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reset_n = reset_n_r;
  assign supply_fail_n = fail_n_r;
  assign chip_sel_out_n = cs_out_r;
  assign chip_sel_pullup = pullup_r;
  assign chip_sel_in_hiz = hiz_r;
  assign ram_rail = rail_r;
  assign backup_connected = backup_supply_in_r;
endmodule : csrw_supervisor
`default_nettype wire

/* File: csrw_supervisor_assertions.sv */
// Port checker for the cpu supervisor
`default_nettype none
module csrw_sup_chk
  import csrw_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_CYC,
  parameter int unsigned WDOG_CYCLES = WDOG_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Design inputs
  input wire csrw_pkg::csrw_cmp_t cmp,
  input wire logic manual_reset_n,
  input wire logic watchdog_toggle_in,
  input wire logic watchdog_driven,
  input wire logic chip_sel_in_n,
  // Design outputs
  input wire logic chip_sel_out_n,
  input wire logic chip_sel_pullup,
  input wire logic chip_sel_in_hiz,
  input wire logic reset_n,
  input wire logic supply_fail_n,
  input wire csrw_pkg::csrw_rail_t ram_rail
);
  logic [15:0] low_cnt_r, ext_cnt_r, wd_cnt_r;
  logic wd_prev_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Run lengths of reset low, gate extension and watchdog silence
  always_ff @(posedge clk)
  begin
    wd_prev_r <= watchdog_toggle_in;
    low_cnt_r <= (!rst_b || reset_n) ? 16'h0000 : low_cnt_r + 16'h0001;
    ext_cnt_r <= (!rst_b || reset_n || chip_sel_out_n) ? 16'h0000
      : ext_cnt_r + 16'h0001;
    wd_cnt_r <= (!rst_b || !reset_n || !watchdog_driven
      || watchdog_toggle_in != wd_prev_r) ? 16'h0000 : wd_cnt_r + 16'h0001;
  end
  a_brownout_low:
    assert property (cmp.below_reset |=> !reset_n)
    else $error("reset not low after supply drop");
  a_hold_min:
    assert property ($rose(reset_n) |-> low_cnt_r >= HOLD_CYCLES)
    else $error("reset released early");
  a_manual_low:
    assert property ((!manual_reset_n) [*8] |-> !reset_n)
    else $error("manual reset ignored");
  a_wdog_bound:
    assert property (wd_cnt_r <= WDOG_CYCLES + 4)
    else $error("watchdog did not expire");
  a_cs_pass:
    assert property (reset_n && $past(reset_n) && !chip_sel_pullup
      |=> chip_sel_out_n == $past(chip_sel_in_n))
    else $error("chip select not passed");
  a_cs_ext:
    assert property (ext_cnt_r <= CS_EXT_CYC + 2)
    else $error("chip select extension too long");
  a_cs_off_hold:
    assert property ((!reset_n && chip_sel_in_n) [*2] |-> chip_sel_out_n)
    else $error("chip select passed during reset");
  a_pullup_out:
    assert property (chip_sel_pullup |-> chip_sel_out_n && chip_sel_in_hiz)
    else $error("pull-up without gate off");
  a_fail_sense:
    assert property (reset_n && $past(reset_n) && $past(cmp.sense_low)
      && !$past(cmp.below_backup) |-> !supply_fail_n)
    else $error("fail flag missed sense");
  a_fail_backup:
    assert property (cmp.below_backup |=> !supply_fail_n)
    else $error("fail flag high below battery");
  a_rail_main:
    assert property ((!cmp.below_reset) [*2] |-> ram_rail == CSRW_RAIL_MAIN)
    else $error("rail not main");
  a_rail_backup:
    assert property ((cmp.below_reset && cmp.below_backup) [*2]
      |-> ram_rail != CSRW_RAIL_MAIN && !reset_n)
    else $error("backup mode wrong");
  // Main scenarios reached
  c_release: cover property ($rose(reset_n));
  c_cs_ext: cover property (!reset_n && !chip_sel_out_n);
  c_backup: cover property (ram_rail == CSRW_RAIL_BACKUP);
endmodule : csrw_sup_chk
bind csrw_supervisor csrw_sup_chk #(
  .HOLD_CYCLES(HOLD_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)
) u_csrw_sup_chk (
  .clk(clk), .rst_b(rst_b), .cmp(cmp), .manual_reset_n(manual_reset_n),
  .watchdog_toggle_in(watchdog_toggle_in),
  .watchdog_driven(watchdog_driven), .chip_sel_in_n(chip_sel_in_n),
  .chip_sel_out_n(chip_sel_out_n), .chip_sel_pullup(chip_sel_pullup),
  .chip_sel_in_hiz(chip_sel_in_hiz), .reset_n(reset_n),
  .supply_fail_n(supply_fail_n), .ram_rail(ram_rail)
);
`default_nettype wire

/* File: csrw_host_model.sv */
// Host model: watchdog service and release of the watchdog line
`default_nettype none
module csrw_host_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control from the bench
  input wire logic wd_on,
  input wire logic wd_drive,
  // Watchdog line
  output logic watchdog_toggle_in,
  output logic watchdog_driven
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rel_r;
  logic [4:0] gap_r;
  assign watchdog_driven = wd_drive;
  // Toggle every 24 cycles; a released line flips once, then stays
  always_ff @(posedge clk)
  begin
    rel_r <= !wd_drive;
    gap_r <= (!rst_b || gap_r == 5'h17) ? 5'h00 : gap_r + 5'h01;
    if (!rst_b)
      watchdog_toggle_in <= 1'b0;
    else if (!wd_drive && !rel_r)
      watchdog_toggle_in <= ~watchdog_toggle_in;
    else if (wd_drive && wd_on && gap_r == 5'h17)
      watchdog_toggle_in <= ~watchdog_toggle_in;
  end
endmodule : csrw_host_model
`default_nettype wire

/* File: csrw_supervisor_tb.sv */
// Self-checking bench for the cpu supervisor
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  num_errors++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module csrw_supervisor_tb
  import csrw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  localparam int WDOG = 80;
  logic clk, rst_b, manual_reset_n, seal_strap_low, chip_sel_in_n;
  logic wd_on, wd_drive, watchdog_toggle_in, watchdog_driven;
  logic chip_sel_out_n, chip_sel_pullup, chip_sel_in_hiz, reset_n;
  logic supply_fail_n, backup_connected;
  csrw_cmp_t cmp;
  csrw_rail_t ram_rail;
  int num_errors, n_compared, cycles, n;
  // Device under test, long counts shortened
  csrw_supervisor #(
    .HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG),
    .WDOG_KEEP_CYCLES(70), .DEB_CYCLES(4)
  ) u_csrw_supervisor (
    .clk(clk), .rst_b(rst_b), .cmp(cmp), .manual_reset_n(manual_reset_n),
    .watchdog_toggle_in(watchdog_toggle_in),
    .watchdog_driven(watchdog_driven), .seal_strap_low(seal_strap_low),
    .chip_sel_in_n(chip_sel_in_n), .chip_sel_out_n(chip_sel_out_n),
    .chip_sel_pullup(chip_sel_pullup), .chip_sel_in_hiz(chip_sel_in_hiz),
    .reset_n(reset_n), .supply_fail_n(supply_fail_n), .ram_rail(ram_rail),
    .backup_connected(backup_connected)
  );
  csrw_host_model u_csrw_host_model (
    .clk(clk), .rst_b(rst_b), .wd_on(wd_on), .wd_drive(wd_drive),
    .watchdog_toggle_in(watchdog_toggle_in),
    .watchdog_driven(watchdog_driven)
  );
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  // Count falling edges until reset_n reaches lvl
  task automatic wait_rst(input logic lvl);
    n = 0;
    while (reset_n !== lvl && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    // Return on a rising edge so callers drive on it
    @(posedge clk);
  endtask : wait_rst
  // Power-up with a brownout in mid-hold
  task automatic t_power();
    cmp <= 3'b101;
    cyc(5);
    cmp.below_reset <= 1'b0;
    cyc(HOLD / 2);
    cmp.below_reset <= 1'b1;
    cyc(3);
    cmp.below_reset <= 1'b0;
    cyc(4);
    @(negedge clk);
    `CHK(supply_fail_n, 1'b1)
    wait_rst(1'b1);
    `CHK(n >= HOLD - 4 && n <= HOLD + 1, 1'b1)
    cyc(3);
    @(negedge clk);
    `CHK(supply_fail_n, 1'b0)
    cyc(1);
    cmp.sense_low <= 1'b0;
  endtask : t_power
  // Short bounces, then a real press
  task automatic t_manual();
    repeat (2)
    begin
      manual_reset_n <= 1'b0;
      cyc(2);
      manual_reset_n <= 1'b1;
      cyc(2);
    end
    @(negedge clk);
    `CHK(reset_n, 1'b1)
    cyc(1);
    manual_reset_n <= 1'b0;
    cyc(12);
    @(negedge clk);
    `CHK(reset_n, 1'b0)
    cyc(1);
    manual_reset_n <= 1'b1;
    wait_rst(1'b1);
    `CHK(n >= HOLD && n <= HOLD + 8, 1'b1)
  endtask : t_manual
  // Host stops service; timer restarts at release
  task automatic t_wdog();
    wd_on <= 1'b0;
    wait_rst(1'b0);
    `CHK(n >= WDOG - 26 && n <= WDOG + 4, 1'b1)
    wait_rst(1'b1);
    `CHK(n >= HOLD && n <= HOLD + 4, 1'b1)
    wait_rst(1'b0);
    `CHK(n >= WDOG - 2 && n <= WDOG + 4, 1'b1)
    cyc(1);
    wd_on <= 1'b1;
    wait_rst(1'b1);
  endtask : t_wdog
  // Released watchdog line never expires
  task automatic t_undriven();
    wd_drive <= 1'b0;
    repeat (3 * WDOG)
    begin
      @(negedge clk);
      `CHK(reset_n, 1'b1)
    end
    cyc(1);
    wd_drive <= 1'b1;
  endtask : t_undriven
  // Gate pass, write extension cut short, blocked hold
  task automatic t_cs();
    chip_sel_in_n <= 1'b0;
    cyc(2);
    @(negedge clk);
    `CHK(chip_sel_out_n, 1'b0)
    `CHK(chip_sel_pullup, 1'b0)
    cyc(1);
    cmp.below_reset <= 1'b1;
    cyc(300);
    @(negedge clk);
    `CHK(chip_sel_out_n, 1'b0)
    cyc(1);
    chip_sel_in_n <= 1'b1;
    cyc(2);
    chip_sel_in_n <= 1'b0;
    cyc(3);
    @(negedge clk);
    `CHK(chip_sel_out_n, 1'b1)
    `CHK(chip_sel_pullup, 1'b1)
    cyc(1);
    cmp.below_reset <= 1'b0;
    repeat (6)
    begin
      cyc(1);
      chip_sel_in_n <= ~chip_sel_in_n;
      @(negedge clk);
      `CHK(chip_sel_out_n, 1'b1)
    end
    cyc(1);
    chip_sel_in_n <= 1'b1;
    wait_rst(1'b1);
  endtask : t_cs
  // Rail choice, backup mode, then the seal
  task automatic t_backup();
    cmp <= 3'b100;
    cyc(3);
    @(negedge clk);
    `CHK(ram_rail, CSRW_RAIL_MAIN)
    cyc(1);
    cmp <= 3'b110;
    cyc(3);
    @(negedge clk);
    `CHK(ram_rail, CSRW_RAIL_BACKUP)
    `CHK(backup_connected, 1'b1)
    `CHK(supply_fail_n, 1'b0)
    `CHK(reset_n, 1'b0)
    cyc(1);
    cmp <= 3'b000;
    seal_strap_low <= 1'b1;
    wait_rst(1'b1);
    cyc(1);
    seal_strap_low <= 1'b0;
    cmp <= 3'b110;
    cyc(3);
    @(negedge clk);
    `CHK(ram_rail, CSRW_RAIL_OFF)
    `CHK(backup_connected, 1'b0)
    cyc(1);
    cmp <= 3'b000;
    cyc(3);
    @(negedge clk);
    `CHK(ram_rail, CSRW_RAIL_MAIN)
    wait_rst(1'b1);
  endtask : t_backup
  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    cmp = 3'b100;
    manual_reset_n = 1'b1;
    seal_strap_low = 1'b0;
    chip_sel_in_n = 1'b1;
    wd_on = 1'b1;
    wd_drive = 1'b1;
    num_errors = 0;
    n_compared = 0;
    cycles = 0;
    cyc(2);
    rst_b <= 1'b1;
    t_power();
    t_manual();
    t_wdog();
    t_undriven();
    t_cs();
    t_backup();
    wrap_up();
  end
endmodule : csrw_supervisor_tb
`default_nettype wire
